// ===== pkg/msr_consts.svh
// Contract
// - Address 0x05 bits 7:0 give supply level code; volts = code x 30 / 255.
// - Address 0x05 bits 15:8 give startup rotor angle plus advance angle.
// - Address 0x06 bits 15:8 give active speed request from selected source.
// - Address 0x06 bits 7:0 give buffered speed request; all ones is full.
// - Address 0x07 bits 9:0 give 10-bit analog speed level sample.
// - Address 0x07 bits 15:10 read zero; host must not rely on them.
// - Address 0x08 bits 15:8 hold the 8-bit silicon ident.
// - Address 0x08 bits 7:0 hold the 8-bit silicon revision code.
// - Addresses 0x09 to 0x2F hold no registers; they read zero and any touch raises unused_hit_q.
`ifndef MSR_CONSTS_SVH
`define MSR_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MSR_ADDR_W 8
`define MSR_DATA_W 16
`define MSR_OFS_POS_SUPPLY 8'h05
`define MSR_OFS_SPEED_CMD 8'h06
`define MSR_OFS_ANALOG_LVL 8'h07
`define MSR_OFS_IDENT 8'h08
`define MSR_OFS_UNUSED_LO 8'h09
`define MSR_OFS_UNUSED_HI 8'h2f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MSR_HI_MSB 15
`define MSR_HI_LSB 8
`define MSR_LO_MSB 7
`define MSR_LO_LSB 0
`define MSR_ANALOG_MSB 9
`define MSR_ANALOG_RSV_LSB 10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MSR_RST_WORD 16'h0000
`define MSR_RST_BYTE 8'h00
`define MSR_RST_ANALOG 10'h000

`endif

// ===== pkg/msr_pkg.sv
package msr_pkg;

  // Where the active speed request comes from
  typedef enum logic [1:0] {
    MSR_SRC_ANALOG,
    MSR_SRC_PWM,
    MSR_SRC_SERIAL
  } msr_speed_src_t;

  // Live status from the motor core
  typedef struct packed {
    logic [7:0] startup_rotor_angle_estimate;
    logic [7:0] advance_angle;
    logic [7:0] supply_level_code;
    logic [9:0] analog_speed_sample;
    logic [7:0] pulse_width_speed_input;
    logic [7:0] serial_speed_request;
    logic [7:0] buffered_speed_request;
  } msr_status_t;

  // Register-level request from the serial register port
  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [7:0] addr;
    logic [15:0] wr_data;
  } msr_req_t;

endpackage

// ===== rtl/msr_status_regs.sv
`timescale 1ns/10ps
`include "msr_consts.svh"

module msr_status_regs #(
  parameter logic [7:0] SILICON_IDENT = 8'h5a, // Arbitrary value
  parameter logic [7:0] SILICON_REVISION_CODE = 8'h3c // Arbitrary value
) (
  input wire logic clk,
  input wire logic srst,
  input wire msr_pkg::msr_status_t status_in,
  input wire msr_pkg::msr_speed_src_t speed_src,
  input wire msr_pkg::msr_req_t req,
  output logic [15:0] rd_data_q,
  output logic rd_valid_q,
  output logic wr_ack_q,
  output logic unused_hit_q
);

  // ----------------------------------------
  // Status snapshot
  // ----------------------------------------
  msr_pkg::msr_status_t snap_q;
  msr_pkg::msr_speed_src_t src_q;
  logic [7:0] rotor_angle_d;
  logic [7:0] active_speed_d;
  logic [15:0] rd_word_d;
  logic in_unused_d;

  // Sampled every cycle so a read sees one coherent copy of all fields
  always_ff @(posedge clk) begin
    if (srst) begin
      snap_q <= '0;
      src_q <= msr_pkg::MSR_SRC_ANALOG;
    end else begin
      snap_q <= status_in;
      src_q <= speed_src;
    end
  end

  // ----------------------------------------
  // Field derivation
  // ----------------------------------------
  // Advance angle wraps modulo one turn, matching the 8-bit angle scale
  assign rotor_angle_d = 8'(snap_q.startup_rotor_angle_estimate + snap_q.advance_angle);

  // Analog source keeps its top eight bits so all ones still means full speed
  always_comb begin
    active_speed_d = `MSR_RST_BYTE;
    unique case (src_q)
      msr_pkg::MSR_SRC_ANALOG: begin
        active_speed_d = snap_q.analog_speed_sample[`MSR_ANALOG_MSB -: 8];
      end
      msr_pkg::MSR_SRC_PWM: begin
        active_speed_d = snap_q.pulse_width_speed_input;
      end
      msr_pkg::MSR_SRC_SERIAL: begin
        active_speed_d = snap_q.serial_speed_request;
      end
      default: begin
        active_speed_d = `MSR_RST_BYTE; // Unused select code reads as stopped
      end
    endcase
  end

  assign in_unused_d = (req.addr >= `MSR_OFS_UNUSED_LO) && (req.addr <= `MSR_OFS_UNUSED_HI);

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  // Anything not mapped returns zero rather than stale bus data
  always_comb begin
    rd_word_d = `MSR_RST_WORD;
    unique case (req.addr)
      `MSR_OFS_POS_SUPPLY: begin
        rd_word_d[`MSR_HI_MSB:`MSR_HI_LSB] = rotor_angle_d;
        rd_word_d[`MSR_LO_MSB:`MSR_LO_LSB] = snap_q.supply_level_code;
      end
      `MSR_OFS_SPEED_CMD: begin
        rd_word_d[`MSR_HI_MSB:`MSR_HI_LSB] = active_speed_d;
        rd_word_d[`MSR_LO_MSB:`MSR_LO_LSB] = snap_q.buffered_speed_request;
      end
      `MSR_OFS_ANALOG_LVL: begin
        rd_word_d[`MSR_ANALOG_MSB:0] = snap_q.analog_speed_sample;
        rd_word_d[`MSR_HI_MSB:`MSR_ANALOG_RSV_LSB] = 6'h00;
      end
      `MSR_OFS_IDENT: begin
        rd_word_d[`MSR_HI_MSB:`MSR_HI_LSB] = SILICON_IDENT;
        rd_word_d[`MSR_LO_MSB:`MSR_LO_LSB] = SILICON_REVISION_CODE;
      end
      default: begin
        rd_word_d = `MSR_RST_WORD;
      end
    endcase
  end

  // ----------------------------------------
  // Read answer
  // ----------------------------------------
  // Data holds between reads so a slow serializer can shift it out
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data_q <= `MSR_RST_WORD;
    end else if (req.rd_en) begin
      rd_data_q <= rd_word_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= req.rd_en;
    end
  end

  // ----------------------------------------
  // Write answer
  // ----------------------------------------
  // Writes are acknowledged so the port never stalls, but nothing is stored
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ack_q <= 1'b0;
    end else begin
      wr_ack_q <= req.wr_en;
    end
  end

  // Flags any touch of the empty window for the host side to log
  always_ff @(posedge clk) begin
    if (srst) begin
      unused_hit_q <= 1'b0;
    end else begin
      unused_hit_q <= (req.rd_en || req.wr_en) && in_unused_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_read_at(logic [7:0] a);
    req.rd_en && !$past(srst) && (req.addr == a);
  endsequence

  sequence s_answer;
    rd_valid_q;
  endsequence

  a_supply_field: assert property (
    s_read_at(`MSR_OFS_POS_SUPPLY) |=> s_answer and
      (rd_data_q[7:0] == $past(status_in.supply_level_code, 2)))
    else $error("supply level field wrong");

  a_rotor_angle_sum: assert property (
    s_read_at(`MSR_OFS_POS_SUPPLY) |=>
      rd_data_q[15:8] == 8'($past(status_in.startup_rotor_angle_estimate, 2)
        + $past(status_in.advance_angle, 2)))
    else $error("rotor angle field wrong");

  a_active_speed_pwm: assert property (
    s_read_at(`MSR_OFS_SPEED_CMD) ##0 ($past(speed_src) == msr_pkg::MSR_SRC_PWM) |=>
      rd_data_q[15:8] == $past(status_in.pulse_width_speed_input, 2))
    else $error("active speed from pwm wrong");

  a_active_speed_ana: assert property (
    s_read_at(`MSR_OFS_SPEED_CMD) ##0 ($past(speed_src) == msr_pkg::MSR_SRC_ANALOG) |=>
      rd_data_q[15:8] == $past(status_in.analog_speed_sample[9:2], 2))
    else $error("active speed from analog wrong");

  a_buffered_speed: assert property (
    s_read_at(`MSR_OFS_SPEED_CMD) |=>
      rd_data_q[7:0] == $past(status_in.buffered_speed_request, 2))
    else $error("buffered speed field wrong");

  a_analog_level: assert property (
    s_read_at(`MSR_OFS_ANALOG_LVL) |=>
      rd_data_q[9:0] == $past(status_in.analog_speed_sample, 2))
    else $error("analog level field wrong");

  a_analog_reserved: assert property (
    s_read_at(`MSR_OFS_ANALOG_LVL) |=> rd_data_q[15:10] == 6'h00)
    else $error("reserved analog bits not zero");

  a_ident_word: assert property (
    req.rd_en && req.addr == `MSR_OFS_IDENT |=>
      rd_data_q == {SILICON_IDENT, SILICON_REVISION_CODE})
    else $error("ident word wrong");

  a_unused_zero: assert property (
    req.rd_en && in_unused_d |=> rd_data_q == 16'h0000 && unused_hit_q)
    else $error("unused address not zero");

  a_write_no_store: assert property (
    req.wr_en && !req.rd_en |=> wr_ack_q && $stable(rd_data_q) && !rd_valid_q)
    else $error("write disturbed read data");

  a_read_holds: assert property (
    rd_valid_q && !req.rd_en |=> $stable(rd_data_q) [*2] or req.rd_en)
    else $error("read data did not hold");

  // ----------------------------------------
  // Register map checks
  // ----------------------------------------
  // Serial source passes the host-written request straight through
  a_active_speed_ser: assert property (
    s_read_at(`MSR_OFS_SPEED_CMD) ##0 ($past(speed_src) == msr_pkg::MSR_SRC_SERIAL) |=>
      rd_data_q[15:8] == $past(status_in.serial_speed_request, 2))
    else $error("active speed from serial wrong");

  // The spare select code must read as a stopped motor
  // Otherwise a glitch on the selector could request full speed
  a_active_speed_off: assert property (
    s_read_at(`MSR_OFS_SPEED_CMD) ##0 (2'($past(speed_src)) == 2'h3) |=>
      rd_data_q[15:8] == 8'h00)
    else $error("spare speed source not zero");

  // Revision byte sits below the ident byte
  a_revision_byte: assert property (
    s_read_at(`MSR_OFS_IDENT) |=> rd_data_q[7:0] == SILICON_REVISION_CODE)
    else $error("revision byte wrong");

  // A read on the first edge after reset sees the cleared snapshot, not live status
  a_first_read_clear: assert property (
    req.rd_en && $past(srst) && (req.addr == `MSR_OFS_POS_SUPPLY) |=>
      rd_data_q == 16'h0000)
    else $error("first read after reset not clear");

  // Addresses above the empty window also read zero
  a_beyond_map_zero: assert property (
    req.rd_en && (req.addr > `MSR_OFS_UNUSED_HI) |=> rd_data_q == 16'h0000)
    else $error("unmapped address not zero");

  // Only a read may move the read word; writes store nothing
  a_data_only_on_read: assert property (
    $changed(rd_data_q) |-> $past(req.rd_en))
    else $error("read word moved without a read");

  // ----------------------------------------
  // Port handshake checks
  // ----------------------------------------
  // Any touch of the empty window, by read or by write
  sequence s_unused_touch;
    (req.rd_en || req.wr_en) && (req.addr >= `MSR_OFS_UNUSED_LO) &&
      (req.addr <= `MSR_OFS_UNUSED_HI);
  endsequence

  // A write strobe taken on this edge
  sequence s_write_taken;
    req.wr_en;
  endsequence

  // Every read strobe is answered on the next edge
  a_read_valid_pulse: assert property (
    req.rd_en |=> rd_valid_q)
    else $error("read not answered");

  // No answer appears without a strobe
  a_no_read_quiet: assert property (
    !req.rd_en |=> !rd_valid_q)
    else $error("read answer without request");

  // Writes are acknowledged so the host never waits
  a_write_ack_pulse: assert property (
    s_write_taken |=> wr_ack_q)
    else $error("write not acknowledged");

  // Acknowledge is a single pulse per strobe
  a_no_write_quiet: assert property (
    !req.wr_en |=> !wr_ack_q)
    else $error("write ack without request");

  // The diagnostic flag follows every touch of the empty window
  a_unused_flag_set: assert property (
    s_unused_touch |=> unused_hit_q)
    else $error("unused touch not flagged");

  // And stays low for mapped or idle cycles
  a_unused_flag_clr: assert property (
    !((req.rd_en || req.wr_en) && (req.addr >= `MSR_OFS_UNUSED_LO) &&
      (req.addr <= `MSR_OFS_UNUSED_HI)) |=> !unused_hit_q)
    else $error("unused flag raised wrongly");

  // A read of the position and supply word at 0x05 never raises the diagnostic flag
  a_pos_not_unused: assert property (
    s_read_at(`MSR_OFS_POS_SUPPLY) |=> !unused_hit_q)
    else $error("mapped read flagged unused");

  // Reset must leave every output quiet on the edge after it
  // This one runs through reset, so it overrides the default disable
  a_reset_clears: assert property (@(posedge clk) disable iff (1'b0)
    $past(srst) |-> !rd_valid_q && !wr_ack_q && !unused_hit_q && (rd_data_q == 16'h0000))
    else $error("outputs not clear after reset");

endmodule

// ===== testbench/msr_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module msr_host_model (
  input wire logic clk,
  output msr_pkg::msr_req_t req
);
  initial begin
    req = '0;
  end
  // One strobe per edge; caller sits just after an edge so requests can run back to back
  task automatic op(input logic rd, input logic wr, input logic [7:0] a, input logic [15:0] d);
    req.rd_en = rd;
    req.wr_en = wr;
    req.addr = a;
    req.wr_data = (a == 8'h07) ? {6'h00, d[9:0]} : d;
    @(posedge clk);
    #1;
  endtask
  // Released lines are scrambled so a stale address never passes for a live one
  task automatic idle();
    req.rd_en = 1'b0;
    req.wr_en = 1'b0;
    req.addr = ~req.addr;
    req.wr_data = ~req.wr_data;
    @(posedge clk);
    #1;
  endtask
endmodule

// ===== testbench/tb_motor_status_readback_regs.sv
`timescale 1ns/10ps
module tb_motor_status_readback_regs;
  localparam logic [7:0] ID_V = 8'ha7; // Arbitrary value
  localparam logic [7:0] REV_V = 8'h4e; // Arbitrary value
  logic clk;
  logic srst;
  msr_pkg::msr_status_t st;
  msr_pkg::msr_speed_src_t src;
  msr_pkg::msr_req_t req;
  logic [15:0] rd_data_q;
  logic rd_valid_q;
  logic wr_ack_q;
  logic unused_hit_q;
  logic [16:0] exp_q[$];
  logic [16:0] wexp_q[$];
  logic [15:0] last_exp = 16'h0000;
  int error_cnt = 0;
  int tests_run = 0;
  int wr_sent = 0;
  int wr_seen = 0;
  msr_status_regs #(.SILICON_IDENT(ID_V), .SILICON_REVISION_CODE(REV_V)) DUT (.clk(clk),
    .srst(srst), .status_in(st), .speed_src(src), .req(req), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .wr_ack_q(wr_ack_q), .unused_hit_q(unused_hit_q));
  msr_host_model host (.clk(clk), .req(req));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Expected word, worked out from the status presented
  function automatic logic [15:0] model(input logic [7:0] a);
    logic [7:0] act;
    case (src)
      msr_pkg::MSR_SRC_ANALOG: act = st.analog_speed_sample[9:2];
      msr_pkg::MSR_SRC_PWM: act = st.pulse_width_speed_input;
      msr_pkg::MSR_SRC_SERIAL: act = st.serial_speed_request;
      default: act = 8'h00;
    endcase
    case (a)
      8'h05: model = {st.startup_rotor_angle_estimate + st.advance_angle, st.supply_level_code};
      8'h06: model = {act, st.buffered_speed_request};
      8'h07: model = {6'h00, st.analog_speed_sample};
      8'h08: model = {ID_V, REV_V};
      default: model = 16'h0000;
    endcase
  endfunction
  task automatic rd(input logic [7:0] a);
    last_exp = model(a);
    exp_q.push_back({(a >= 8'h09 && a <= 8'h2f), last_exp});
    host.op(1'b1, 1'b0, a, 16'($urandom));
  endtask
  task automatic wr(input logic [7:0] a);
    wr_sent++;
    wexp_q.push_back({(a >= 8'h09 && a <= 8'h2f), last_exp});
    host.op(1'b0, 1'b1, a, 16'($urandom));
  endtask
  // Oldest note is matched against each read answer and each write acknowledge
  always @(posedge clk) begin
    if (wr_ack_q === 1'b1) begin
      wr_seen++;
      if (wexp_q.size() != 0)
        check("write answer", {unused_hit_q, rd_data_q}, wexp_q.pop_front());
    end
    if (rd_valid_q === 1'b1) begin
      if (exp_q.size() == 0)
        check("unexpected read", 17'h00000, 17'h1ffff);
      else
        check("read word", {unused_hit_q, rd_data_q}, exp_q.pop_front());
    end
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(97));
    srst = 1'b1;
    src = msr_pkg::MSR_SRC_PWM;
    st = msr_pkg::msr_status_t'(58'({$urandom, $urandom}));
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    // Snapshot is still clear on the first read after reset
    exp_q.push_back(17'h00000);
    host.op(1'b1, 1'b0, 8'h05, 16'h0000);
    host.idle();
    for (int i = 0; i < 12; i++) begin
      st = msr_pkg::msr_status_t'(58'({$urandom, $urandom}));
      src = msr_pkg::msr_speed_src_t'(i[1:0]);
      host.idle();
      host.idle();
      for (int a = 5; a <= 8; a++) begin
        rd(8'(a));
        wr(8'(a));
      end
      wr(8'h09 + 8'($urandom_range(0, 38)));
      rd(8'h09 + 8'($urandom_range(0, 38)));
      rd(8'h09);
      rd(8'h2f);
      rd(8'h30);
      rd(8'h06);
      host.idle();
    end
    for (int k = 0; k < 20 && exp_q.size() != 0; k++)
      @(posedge clk);
    check("answers pending", 17'(exp_q.size()), 17'h00000);
    check("write acks", 17'(wr_seen), 17'(wr_sent));
    end_sim();
  end
endmodule
